// ==== lock_defines.svh ====
// constants for the block lock and software reset command logic
// assumes a 20 MHz system clock; included by bare name
`ifndef LOCK_DEFINES_SVH
`define LOCK_DEFINES_SVH
`define OP_READ_LOCK 8'h3D
`define OP_GLOBAL_LOCK 8'h7E
`define OP_GLOBAL_UNLOCK 8'h98
`define OP_LOCK_ONE 8'h36
`define OP_UNLOCK_ONE 8'h39
`define OP_RESET_ENABLE 8'h66
`define OP_RESET_DEVICE 8'h99
`define OP_PAGE_PROGRAM 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE32 8'h52
`define OP_BLOCK_ERASE64 8'hD8
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define ADDR_BITS 24
`define OPCODE_BITS 8
`define BIT_COUNT_W 6
`define PIN_IDLE_LEVELS 3'h4
`define RESET_TIME_NS 30000
`define CLK_PERIOD_NS 50
`define RESET_CYCLES ((`RESET_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCKED_BYTE 8'h01
`define UNLOCKED_BYTE 8'h00
`endif

// ==== lock_pkg.sv ====
// types for the block lock and software reset command logic
// assumes lock_defines.svh provides the constants
package lock_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_OUT,
		ST_WAIT_END,
		ST_RECOVER
	} cmd_state_t;
endpackage : lock_pkg

// ==== pin_sync.sv ====
// two flip-flop synchroniser for a group of pin inputs
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// pins
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule : pin_sync

// ==== flash_block_lock_and_reset.sv ====
// command decoder for per-block lock bits and the two-step software reset
// assumes the spi pins arrive asynchronously and are sampled on mclk
//
// Overview of operation
// - lock bits guard only when scheme select set
// - lock bits volatile, all set at reset
// - read lock: 3Dh plus 24-bit address, rising edges
// - lock value out on falling edges, msb first
// - lsb one means locked, zero unlocked
// - 7Eh alone then deselect locks every block
// - 98h alone then deselect unlocks every block
// - global commands need write permit latch set
// - software reset clears volatile state and aborts
// - reset only when 66h directly precedes 99h
// - other command after 66h cancels reset enable
// - ignore commands about 30us after reset
// - 36h plus address locks one block, needs latch
// - 39h plus address unlocks one block, needs latch
`timescale 1ns/1ps
`include "lock_defines.svh"
module flash_block_lock_and_reset
	import lock_pkg::*;
#(
	parameter int NUM_BLOCKS = 64,
	parameter int BLOCK_SHIFT = 16,
	parameter int RESET_CYCLES = `RESET_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// spi pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// protection status bits
	input wire logic protection_scheme_select,
	input wire logic complement_protect,
	input wire logic sector_granularity_select,
	input wire logic top_bottom_select,
	input wire logic [2:0] range_protect_bits,
	input wire logic range_protected,
	// volatile state owned here
	output logic write_permit_latch,
	output logic suspended_flag,
	output logic [2:0] wrap_length_bits,
	output logic reset_busy,
	// array operation requests
	output logic op_start,
	output logic [7:0] op_code,
	output logic [`ADDR_BITS-1:0] op_addr,
	output logic op_abort,
	output logic [NUM_BLOCKS-1:0] lock_bits
);
	localparam int BW = $clog2(NUM_BLOCKS);
	localparam int RW = $clog2(RESET_CYCLES + 1);

	function automatic logic is_array_write(input logic [7:0] op);
		return op == `OP_PAGE_PROGRAM || op == `OP_SECTOR_ERASE ||
			op == `OP_BLOCK_ERASE32 || op == `OP_BLOCK_ERASE64;
	endfunction : is_array_write

	function automatic logic needs_addr(input logic [7:0] op);
		return op == `OP_READ_LOCK || op == `OP_LOCK_ONE || op == `OP_UNLOCK_ONE ||
			is_array_write(op);
	endfunction : needs_addr

	////////////////////////////////////////////////////////////////////////
	// pin sampling and edge detection
	logic cs_n_s, sclk_s, sin_s;
	logic sclk_d_reg;
	logic cs_n_d_reg;
	// resets to idle pin levels so no false select edge follows reset
	pin_sync #(.WIDTH(3), .RST_VAL(`PIN_IDLE_LEVELS)) u_sync (
		.clk(mclk),
		.rst(sys_rst),
		.din({cs_n, sclk, serial_in}),
		.dout({cs_n_s, sclk_s, sin_s})
	);
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_d_reg <= 1'b0;
			cs_n_d_reg <= 1'b1;
		end else begin
			sclk_d_reg <= sclk_s;
			cs_n_d_reg <= cs_n_s;
		end
	end
	wire sclk_rise = sclk_s & ~sclk_d_reg;
	wire sclk_fall = ~sclk_s & sclk_d_reg;
	wire cs_rise = cs_n_s & ~cs_n_d_reg;

	////////////////////////////////////////////////////////////////////////
	// command shifter
	cmd_state_t state_reg;
	logic [7:0] opc_reg;
	logic [`ADDR_BITS-1:0] addr_reg;
	logic [`BIT_COUNT_W-1:0] cnt_reg;
	logic [7:0] out_reg;
	logic [RW-1:0] rst_cnt_reg;
	logic reset_enable_reg;
	wire [7:0] opc_next = {opc_reg[6:0], sin_s};
	wire [`ADDR_BITS-1:0] addr_next = {addr_reg[`ADDR_BITS-2:0], sin_s};
	wire [BW-1:0] blk_idx = BW'(addr_next >> BLOCK_SHIFT);
	wire opc_done = state_reg == ST_OPCODE && sclk_rise &&
		cnt_reg == `BIT_COUNT_W'(`OPCODE_BITS - 1);
	wire addr_done = state_reg == ST_ADDR && sclk_rise &&
		cnt_reg == `BIT_COUNT_W'(`ADDR_BITS - 1);
	wire [BW-1:0] op_blk = BW'(addr_reg >> BLOCK_SHIFT);
	wire frame_end = cs_rise && state_reg != ST_RECOVER;
	wire do_reset = frame_end && state_reg == ST_WAIT_END &&
		opc_reg == `OP_RESET_DEVICE && reset_enable_reg;
	wire cmd_done = frame_end && state_reg == ST_WAIT_END;

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			opc_reg <= 8'h00;
			addr_reg <= '0;
			cnt_reg <= '0;
			rst_cnt_reg <= '0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (!cs_n_s) begin
						state_reg <= ST_OPCODE;
						cnt_reg <= '0;
					end
				end
				ST_OPCODE: begin
					if (cs_n_s) begin
						state_reg <= ST_IDLE;
					end else if (sclk_rise) begin
						opc_reg <= opc_next;
						cnt_reg <= cnt_reg + 1'b1;
						if (opc_done) begin
							cnt_reg <= '0;
							state_reg <= needs_addr(opc_next) ? ST_ADDR : ST_WAIT_END;
						end
					end
				end
				ST_ADDR: begin
					if (cs_n_s) begin
						state_reg <= ST_IDLE;
					end else if (sclk_rise) begin
						addr_reg <= addr_next;
						cnt_reg <= cnt_reg + 1'b1;
						if (addr_done) begin
							state_reg <= opc_reg == `OP_READ_LOCK ? ST_OUT : ST_WAIT_END;
						end
					end
				end
				ST_OUT: begin
					if (cs_n_s) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_WAIT_END: begin
					if (do_reset) begin
						state_reg <= ST_RECOVER;
						rst_cnt_reg <= RW'(RESET_CYCLES);
					end else if (cs_n_s) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_RECOVER: begin
					if (rst_cnt_reg != '0) begin
						rst_cnt_reg <= rst_cnt_reg - 1'b1;
					end else if (cs_n_s) begin
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset enable tracking
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			reset_enable_reg <= 1'b0;
		end else if (cmd_done || (frame_end && state_reg != ST_IDLE)) begin
			reset_enable_reg <= cmd_done && opc_reg == `OP_RESET_ENABLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock bits
	wire wel_ok = write_permit_latch;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_bits <= '1;
		end else if (do_reset) begin
			lock_bits <= '1;
		end else if (cmd_done && wel_ok) begin
			if (opc_reg == `OP_GLOBAL_LOCK) begin
				lock_bits <= '1;
			end else if (opc_reg == `OP_GLOBAL_UNLOCK) begin
				lock_bits <= '0;
			end else if (opc_reg == `OP_LOCK_ONE) begin
				lock_bits[op_blk] <= 1'b1;
			end else if (opc_reg == `OP_UNLOCK_ONE) begin
				lock_bits[op_blk] <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write permit latch and other volatile settings
	wire write_cmd = cmd_done && (opc_reg == `OP_GLOBAL_LOCK ||
		opc_reg == `OP_GLOBAL_UNLOCK || opc_reg == `OP_LOCK_ONE ||
		opc_reg == `OP_UNLOCK_ONE || opc_reg == `OP_WRITE_DISABLE ||
		is_array_write(opc_reg));
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			write_permit_latch <= 1'b0;
			suspended_flag <= 1'b0;
			wrap_length_bits <= 3'h0;
		end else if (do_reset) begin
			write_permit_latch <= 1'b0;
			suspended_flag <= 1'b0;
			wrap_length_bits <= 3'h0;
		end else if (cmd_done && opc_reg == `OP_WRITE_ENABLE) begin
			write_permit_latch <= 1'b1;
		end else if (write_cmd) begin
			write_permit_latch <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// array operation requests
	wire blk_locked = protection_scheme_select && lock_bits[op_blk];
	wire arr_ok = protection_scheme_select ? !blk_locked : !range_protected;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			op_start <= 1'b0;
			op_code <= 8'h00;
			op_addr <= '0;
			op_abort <= 1'b0;
			reset_busy <= 1'b0;
		end else begin
			op_start <= cmd_done && is_array_write(opc_reg) && wel_ok && arr_ok;
			op_abort <= do_reset;
			reset_busy <= do_reset || (state_reg == ST_RECOVER && rst_cnt_reg != '0);
			if (cmd_done) begin
				op_code <= opc_reg;
				op_addr <= addr_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock value output
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			out_reg <= 8'h00;
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (addr_done && opc_reg == `OP_READ_LOCK) begin
			out_reg <= lock_bits[blk_idx] ? `LOCKED_BYTE : `UNLOCKED_BYTE;
		end else if (state_reg == ST_OUT && cs_n_s) begin
			serial_out_oe <= 1'b0;
		end else if (state_reg == ST_OUT && sclk_fall) begin
			serial_out <= out_reg[7];
			serial_out_oe <= 1'b1;
			out_reg <= {out_reg[6:0], out_reg[7]};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	global_lock_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cmd_done && wel_ok && opc_reg == `OP_GLOBAL_LOCK |=> lock_bits == '1)
		else $error("global lock missed");
	global_unlock_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cmd_done && wel_ok && opc_reg == `OP_GLOBAL_UNLOCK |=> lock_bits == '0)
		else $error("global unlock missed");
	latch_guard_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cmd_done && !wel_ok && !do_reset |=> $stable(lock_bits))
		else $error("lock changed without latch");
	reset_clears_a: assert property (@(posedge mclk) disable iff (sys_rst)
		do_reset |=> !write_permit_latch && lock_bits == '1 && op_abort)
		else $error("reset left state");
	reset_pair_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(reset_enable_reg) |-> $past(cmd_done && opc_reg == `OP_RESET_ENABLE))
		else $error("reset enable armed without enable frame");
	enable_cancel_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cmd_done && opc_reg != `OP_RESET_ENABLE && opc_reg != `OP_RESET_DEVICE
		|=> !reset_enable_reg)
		else $error("reset enable kept");
	recover_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		do_reset |=> state_reg == ST_RECOVER [*8])
		else $error("recovery cut short");
	locked_block_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cmd_done && protection_scheme_select && lock_bits[op_blk] |=> !op_start)
		else $error("locked block written");
	out_oe_a: assert property (@(posedge mclk) disable iff (sys_rst)
		serial_out_oe |-> $past(state_reg == ST_OUT))
		else $error("output driven outside read");
	read_cov: cover property (@(posedge mclk) disable iff (sys_rst)
		state_reg == ST_OUT && sclk_fall);
	reset_cov: cover property (@(posedge mclk) disable iff (sys_rst) do_reset);
	unlock_cov: cover property (@(posedge mclk) disable iff (sys_rst)
		cmd_done && wel_ok && opc_reg == `OP_GLOBAL_UNLOCK);
endmodule : flash_block_lock_and_reset

// ==== spi_host_model.sv ====
// spi host model for the flash pins, mode 0, sclk idle low
// assumes mclk at 50 ns; one sclk half period is four mclk cycles (400 ns sclk)
`timescale 1ns/1ps
module spi_host_model (
	// clock
	input wire logic mclk,
	// spi pins
	output logic cs_n,
	output logic sclk,
	output logic serial_in,
	input wire logic so_pin
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		serial_in = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic half();
		repeat (4) @(negedge mclk);
	endtask : half

	// one whole frame: opcode, na address bits, nrd output bits
	task automatic xfer(input logic [7:0] op, input logic [23:0] addr, input int na,
		input int nrd, output logic [7:0] rd);
		logic [31:0] sh;
		sh = {op, addr};
		rd = 8'h00;
		cs_n = 1'b0;
		half();
		for (int i = 0; i < 8 + na; i++) begin
			serial_in = sh[31 - i];
			half();
			sclk = 1'b1;
			half();
			sclk = 1'b0;
		end
		for (int i = 0; i < nrd; i++) begin
			half();
			sclk = 1'b1;
			half();
			rd = {rd[6:0], so_pin};
			sclk = 1'b0;
		end
		half();
		cs_n = 1'b1;
		serial_in = ~serial_in;
		half();
		half();
	endtask : xfer
endmodule : spi_host_model

// ==== testbench.sv ====
// self-checking bench for the block lock and software reset command logic
// assumes spi_host_model as far side and a shortened recovery count
`timescale 1ns/1ps
`include "lock_defines.svh"
module testbench
	import lock_pkg::*;
;
	localparam int RC = 200;
	logic mclk, sys_rst, cs_n, sclk, serial_in, serial_out, serial_out_oe, so_last, so_pin;
	logic pss, range_protected, write_permit_latch, suspended_flag, reset_busy;
	logic op_start, op_abort;
	logic [2:0] wrap_length_bits;
	logic [7:0] op_code, rd;
	logic [23:0] op_addr;
	logic [63:0] lock_bits;
	int n_errors = 0;
	int checks = 0;
	int n_start = 0;
	int n_abort = 0;
	int busy_len = 0;

	////////////////////////////////////////////////////////////////////////////////
	flash_block_lock_and_reset #(.RESET_CYCLES(RC)) flash_block_lock_and_reset_inst (
		.mclk(mclk), .sys_rst(sys_rst), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.protection_scheme_select(pss), .complement_protect(1'b0),
		.sector_granularity_select(1'b0), .top_bottom_select(1'b0),
		.range_protect_bits(3'h0), .range_protected(range_protected),
		.write_permit_latch(write_permit_latch), .suspended_flag(suspended_flag),
		.wrap_length_bits(wrap_length_bits), .reset_busy(reset_busy), .op_start(op_start),
		.op_code(op_code), .op_addr(op_addr), .op_abort(op_abort), .lock_bits(lock_bits));
	spi_host_model spi_host_model_inst (
		.mclk(mclk), .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in), .so_pin(so_pin));

	// released output line shows the inverse of its last value
	assign so_pin = serial_out_oe ? serial_out : ~so_last;
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		if (op_start === 1'b1) n_start <= n_start + 1;
		if (op_abort === 1'b1) n_abort <= n_abort + 1;
		if (reset_busy === 1'b1) busy_len <= busy_len + 1;
		if (serial_out_oe === 1'b1) so_last <= serial_out;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic report_and_stop();
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int na);
		spi_host_model_inst.xfer(op, a, na, 0, rd);
	endtask : cmd

	// write enable frame, then the command
	task automatic wcmd(input logic [7:0] op, input logic [23:0] a, input int na);
		cmd(`OP_WRITE_ENABLE, 24'h0, 0);
		cmd(op, a, na);
	endtask : wcmd

	task automatic rdlock(input logic [7:0] blk, input logic [7:0] exp);
		spi_host_model_inst.xfer(`OP_READ_LOCK, {blk, 16'h0000}, 24, 8, rd);
		chk("lock byte", 64'(exp), 64'(rd));
		chk("output enable", 64'h0, 64'(serial_out_oe));
	endtask : rdlock

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		so_last = 1'b0;
		sys_rst = 1'b1;
		pss = 1'b1;
		range_protected = 1'b0;
		repeat (16) @(negedge mclk);
		sys_rst = 1'b0;
		repeat (4) @(negedge mclk);
		chk("lock bits", {64{1'b1}}, lock_bits);
		rdlock(8'h05, `LOCKED_BYTE);
		cmd(`OP_GLOBAL_UNLOCK, 24'h0, 0);
		chk("lock bits", {64{1'b1}}, lock_bits);
		wcmd(`OP_GLOBAL_UNLOCK, 24'h0, 0);
		chk("lock bits", 64'h0, lock_bits);
		rdlock(8'h05, `UNLOCKED_BYTE);
		wcmd(`OP_LOCK_ONE, 24'h03_0000, 24);
		chk("lock bits", 64'h8, lock_bits);
		rdlock(8'h03, `LOCKED_BYTE);
		wcmd(`OP_PAGE_PROGRAM, 24'h03_0010, 24);
		chk("op starts", 64'h0, 64'(n_start));
		wcmd(`OP_PAGE_PROGRAM, 24'h04_0010, 24);
		chk("op starts", 64'h1, 64'(n_start));
		chk("op addr", 64'h04_0010, 64'(op_addr));
		chk("op code", 64'(`OP_PAGE_PROGRAM), 64'(op_code));
		pss = 1'b0;
		wcmd(`OP_SECTOR_ERASE, 24'h03_0000, 24);
		chk("op starts", 64'h2, 64'(n_start));
		range_protected = 1'b1;
		wcmd(`OP_SECTOR_ERASE, 24'h05_0000, 24);
		chk("op starts", 64'h2, 64'(n_start));
		range_protected = 1'b0;
		pss = 1'b1;
		wcmd(`OP_UNLOCK_ONE, 24'h03_0000, 24);
		chk("lock bits", 64'h0, lock_bits);
		wcmd(`OP_GLOBAL_LOCK, 24'h0, 0);
		chk("lock bits", {64{1'b1}}, lock_bits);
		wcmd(`OP_GLOBAL_UNLOCK, 24'h0, 0);
		chk("suspend", 64'h0, 64'(suspended_flag));
		chk("busy", 64'h0, 64'(reset_busy));
		cmd(`OP_RESET_ENABLE, 24'h0, 0);
		cmd(`OP_WRITE_ENABLE, 24'h0, 0);
		cmd(`OP_RESET_DEVICE, 24'h0, 0);
		chk("aborts", 64'h0, 64'(n_abort));
		chk("lock bits", 64'h0, lock_bits);
		cmd(`OP_RESET_ENABLE, 24'h0, 0);
		cmd(`OP_RESET_DEVICE, 24'h0, 0);
		chk("aborts", 64'h1, 64'(n_abort));
		chk("lock bits", {64{1'b1}}, lock_bits);
		chk("latch", 64'h0, 64'(write_permit_latch));
		chk("sus wrap", 64'h0, 64'({suspended_flag, wrap_length_bits}));
		cmd(`OP_WRITE_ENABLE, 24'h0, 0);
		chk("busy", 64'h1, 64'(reset_busy));
		chk("latch", 64'h0, 64'(write_permit_latch));
		for (int i = 0; reset_busy !== 1'b0; i++) begin
			if (i > 400) begin
				n_errors++;
				report_and_stop();
			end
			@(negedge mclk);
		end
		chk("busy cycles", 64'(RC + 1), 64'(busy_len));
		cmd(`OP_WRITE_ENABLE, 24'h0, 0);
		chk("latch", 64'h1, 64'(write_permit_latch));
		report_and_stop();
	end
endmodule : testbench
